// ===== logic/diag_record_regs.svh
// Purpose: Constants of the analog input scaling and its diagnostic record.
// Assumes: One 40 MHz core clock; record bytes are addressed from zero.
// Notes: Byte offsets count from the first byte of the full record.
// Function
// - Wide mode scales 10 V to 27648, range -4864 to 32511.
// - Narrow mode scales 10 V to 16384, range -3277 to 20480.
// - Function number 10h selects wide scaling, 20h selects narrow scaling.
// - No interrupt; channel errors light the channel LED and enter the record.
// - Record holds parameter errors, range overflow and range underflow.
// - Record set 01h reads the whole record, 00h its first 4 bytes.
// - Index 2F01h reads the whole record, 2F00h its first 4 bytes.
// - Index 5005h gives one byte per subindex, first byte at 02h.
// - Summary bits fail, internal, external, channel, supply 0-4; param 7.
// - Module class byte is analog class 0101b with channel info bit 4.
// - Internal diagnostic byte sets bit 4 on internal communication error.
// - Channel type byte reports analog input, 71h.
// - Diagnostic bits per channel byte reports 08h.
// - Channel count byte reports 08h.
// - Channel error map bit n is set while channel n has an error.
// - After the map come eight detail bytes and a 4-byte stamp, all 00h after reset.
// - Detail byte bit 0 parameter error, bit 6 underflow, bit 7 overflow.
// - Microsecond ticker starts at 0, wraps, captured on each event.
// - Function number FFh deactivates a channel; it measures nothing.
`ifndef DIAG_RECORD_REGS_SVH
`define DIAG_RECORD_REGS_SVH

// ----------------------------------------------------------------------------
// Access selectors
// ----------------------------------------------------------------------------
`define RS_FULL 16'h0001
`define RS_SHORT 16'h0000
`define IX_FULL 16'h2F01
`define IX_SHORT 16'h2F00
`define SX_INDEX 16'h5005
`define SX_FIRST 8'h02
`define REC_LEN 8'h14
`define SHORT_LEN 8'h04

// ----------------------------------------------------------------------------
// Record byte offsets
// ----------------------------------------------------------------------------
`define OFS_SUMMARY 8'h00
`define OFS_CLASS 8'h01
`define OFS_RSVD 8'h02
`define OFS_INTERNAL 8'h03
`define OFS_CHTYPE 8'h04
`define OFS_BITS 8'h05
`define OFS_COUNT 8'h06
`define OFS_MAP 8'h07
`define OFS_DETAIL 8'h08
`define OFS_STAMP 8'h10

// ----------------------------------------------------------------------------
// Fixed record contents and field positions
// ----------------------------------------------------------------------------
`define CLASS_INFO 8'h15
`define CHAN_TYPE 8'h71
`define BITS_PER_CH 8'h08
`define CHAN_COUNT 8'h08
`define RSVD_VALUE 8'h00
`define AUX_SYNC_RST 2'b11
`define SUM_FAIL 0
`define SUM_INTERNAL 1
`define SUM_EXTERNAL 2
`define SUM_CHANNEL 3
`define SUM_SUPPLY 4
`define SUM_PARAM 7
`define INT_COMM 4
`define DET_PARAM 0
`define DET_UNDER 6
`define DET_OVER 7

// ----------------------------------------------------------------------------
// Channel function numbers and scaling
// ----------------------------------------------------------------------------
`define FN_WIDE 8'h10
`define FN_NARROW 8'h20
`define FN_OFF 8'hFF
`define CODE_FRAC 14
`define WIDE_NOM 36'sd27648
`define WIDE_MAX 36'sd32511
`define WIDE_MIN (-36'sd4864)
`define NARROW_MAX 36'sd20480
`define NARROW_MIN (-36'sd3277)
`define CLAMP_HI 16'h7FFF
`define CLAMP_LO 16'h8000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TICK_NS 1000
`define CLK_NS 25
`define TICK_CYCLES (`TICK_NS / `CLK_NS)

`endif

// ===== logic/diag_record_pkg.sv
// Purpose: Types shared by the diagnostic record block and its users.
// Assumes: Constants come from diag_record_regs.svh.
// Notes: Requests and answers travel as packed structs.
package diag_record_pkg;

  typedef enum logic [1:0] {
    acc_record_set,
    acc_object_index,
    acc_object_subindex
  } access_kind_t;

  typedef struct packed {
    logic valid;
    access_kind_t kind;
    logic [15:0] selector;
    logic [7:0] byte_sel;
  } rec_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [7:0] data;
  } rec_rsp_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic signed [17:0] code;
  } sample_t;

  typedef struct packed {
    logic [5:0] pre;
    logic [31:0] ticker;
    logic [1:0] aux_sync;
    logic [7:0] summary;
    logic [7:0] internal;
    logic [7:0] err_map;
    logic [7:0][7:0] detail;
    logic [31:0] stamp;
    logic [7:0][15:0] meas;
    logic [7:0] led;
    rec_rsp_t rsp;
  } state_t;

endpackage

// ===== logic/analog_input_diag_record.sv
// Purpose: Eight-channel 0 to 10 V scaling with a readable diagnostic record.
// Assumes: Samples and requests come from logic on core_clk.
// Notes: Sample code is signed with 16384 counts per 10 V.
`timescale 1ns/100ps
`include "diag_record_regs.svh"

module analog_input_diag_record (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Channel setup and samples
  input wire logic [7:0][7:0] channel_function_number,
  input wire diag_record_pkg::sample_t sample,
  // Module status inputs
  input wire logic aux_supply_ok,
  input wire logic internal_comm_err,
  // Record access
  input wire diag_record_pkg::rec_req_t rec_req,
  output diag_record_pkg::rec_rsp_t rec_rsp,
  // Measurements and indicators
  output logic [7:0][15:0] meas_value,
  output logic [7:0] chan_led
);
  import diag_record_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic fn_bad(input logic [7:0] fn);
    fn_bad = (fn != `FN_WIDE) && (fn != `FN_NARROW) && (fn != `FN_OFF);
  endfunction

  function automatic logic [7:0] rec_byte(input state_t s,
                                          input logic [7:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx == `OFS_SUMMARY) begin
      b = s.summary;
    end else if (idx == `OFS_CLASS) begin
      b = `CLASS_INFO;
    end else if (idx == `OFS_RSVD) begin
      b = `RSVD_VALUE;
    end else if (idx == `OFS_INTERNAL) begin
      b = s.internal;
    end else if (idx == `OFS_CHTYPE) begin
      b = `CHAN_TYPE;
    end else if (idx == `OFS_BITS) begin
      b = `BITS_PER_CH;
    end else if (idx == `OFS_COUNT) begin
      b = `CHAN_COUNT;
    end else if (idx == `OFS_MAP) begin
      b = s.err_map;
    end else if (idx < `OFS_STAMP) begin
      b = s.detail[idx[2:0]];
    end else if (idx < `REC_LEN) begin
      b = s.stamp[idx[1:0]*8 +: 8];
    end
    rec_byte = b;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  state_t s_q;
  state_t s_d;

  always_comb begin
    logic [7:0] fn;
    logic signed [35:0] cx;
    logic signed [35:0] d;
    logic signed [35:0] dmax;
    logic signed [35:0] dmin;
    logic [7:0] lim;
    logic [7:0] idx;
    logic rising;
    fn = 8'h00;
    cx = 36'sd0;
    d = 36'sd0;
    dmax = 36'sd0;
    dmin = 36'sd0;
    lim = 8'h00;
    idx = 8'h00;
    rising = 1'b0;
    s_d = s_q;

    // Free-running microsecond ticker, wraps naturally at 2^32.
    if (s_q.pre == 6'(`TICK_CYCLES - 1)) begin
      s_d.pre = 6'd0;
      s_d.ticker = s_q.ticker + 32'h0000_0001;
    end else begin
      s_d.pre = s_q.pre + 6'd1;
    end

    // The supply flag is a pin; only the second stage is ever read.
    s_d.aux_sync = {s_q.aux_sync[0], aux_supply_ok};

    // Parameter errors follow the setup continuously.
    for (int i = 0; i < 8; i++) begin
      s_d.detail[i][`DET_PARAM] =
        fn_bad(channel_function_number[i]);
      if (channel_function_number[i] == `FN_OFF) begin
        s_d.detail[i][`DET_UNDER] = 1'b0;
        s_d.detail[i][`DET_OVER] = 1'b0;
        s_d.meas[i] = 16'h0000;
      end
    end

    // Scale the newest sample; range flags track the latest reading.
    if (sample.valid) begin
      fn = channel_function_number[sample.chan];
      cx = 36'(sample.code);
      if (fn == `FN_WIDE) begin
        d = (cx * `WIDE_NOM) >>> `CODE_FRAC;
        dmax = `WIDE_MAX;
        dmin = `WIDE_MIN;
      end else begin
        d = cx;
        dmax = `NARROW_MAX;
        dmin = `NARROW_MIN;
      end
      if ((fn == `FN_WIDE) || (fn == `FN_NARROW)) begin
        s_d.detail[sample.chan][`DET_OVER] = (d > dmax);
        s_d.detail[sample.chan][`DET_UNDER] = (d < dmin);
        if (d > dmax) begin
          s_d.meas[sample.chan] = `CLAMP_HI;
        end else if (d < dmin) begin
          s_d.meas[sample.chan] = `CLAMP_LO;
        end else begin
          s_d.meas[sample.chan] = d[15:0];
        end
      end
    end

    // Bits 5 to 1 of each detail byte stay reserved.
    for (int i = 0; i < 8; i++) begin
      s_d.detail[i][5:1] = 5'h00;
      s_d.err_map[i] = |s_d.detail[i];
    end

    // The summary and internal bytes derive from the present faults.
    s_d.internal = 8'h00;
    s_d.internal[`INT_COMM] = internal_comm_err;
    s_d.summary = 8'h00;
    s_d.summary[`SUM_CHANNEL] = |s_d.err_map;
    s_d.summary[`SUM_INTERNAL] = internal_comm_err;
    s_d.summary[`SUM_SUPPLY] = ~s_q.aux_sync[1];
    for (int i = 0; i < 8; i++) begin
      if (s_d.detail[i][`DET_PARAM]) begin
        s_d.summary[`SUM_PARAM] = 1'b1;
      end
      if (s_d.detail[i][`DET_OVER] || s_d.detail[i][`DET_UNDER]) begin
        s_d.summary[`SUM_EXTERNAL] = 1'b1;
      end
    end
    s_d.summary[`SUM_EXTERNAL] = s_d.summary[`SUM_EXTERNAL] |
                                 s_d.summary[`SUM_SUPPLY];
    s_d.summary[`SUM_FAIL] = s_d.summary[`SUM_INTERNAL] |
                             s_d.summary[`SUM_SUPPLY];

    // A newly raised flag stamps the record with the ticker value.
    rising = |({s_d.summary, s_d.internal, s_d.err_map, s_d.detail} &
               ~{s_q.summary, s_q.internal, s_q.err_map, s_q.detail});
    if (rising) begin
      s_d.stamp = s_q.ticker;
    end

    // Faulty channels light their indicator; there is no interrupt.
    s_d.led = s_d.err_map;

    // Record reads answer one cycle after the request.
    s_d.rsp = '0;
    if (rec_req.valid) begin
      s_d.rsp.ack = 1'b1;
      lim = 8'h00;
      idx = rec_req.byte_sel;
      if (rec_req.kind == acc_record_set) begin
        if (rec_req.selector == `RS_FULL) begin
          lim = `REC_LEN;
        end else if (rec_req.selector == `RS_SHORT) begin
          lim = `SHORT_LEN;
        end
      end else if (rec_req.kind == acc_object_index) begin
        if (rec_req.selector == `IX_FULL) begin
          lim = `REC_LEN;
        end else if (rec_req.selector == `IX_SHORT) begin
          lim = `SHORT_LEN;
        end
      end else if (rec_req.kind == acc_object_subindex) begin
        if ((rec_req.selector == `SX_INDEX) &&
            (rec_req.byte_sel >= `SX_FIRST)) begin
          lim = `REC_LEN;
          idx = rec_req.byte_sel - `SX_FIRST;
        end
      end
      if (idx < lim) begin
        s_d.rsp.data = rec_byte(s_q, idx);
      end else begin
        s_d.rsp.err = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      // The supply sync starts as present, so no false event follows reset.
      s_q.aux_sync <= `AUX_SYNC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rec_rsp = s_q.rsp;
  assign meas_value = s_q.meas;
  assign chan_led = s_q.led;

endmodule

// ===== test/diag_record_props.sv
// Purpose: Port-level properties of the diagnostic record block.
// Assumes: One clock core_clk with asynchronous active-low rstn.
// Notes: Sees only the top module ports; attached by bind below.
`timescale 1ns/100ps
module diag_record_props
  import diag_record_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Channel and status inputs
  input wire logic [7:0][7:0] channel_function_number,
  input wire diag_record_pkg::sample_t sample,
  input wire logic aux_supply_ok,
  input wire logic internal_comm_err,
  // Record bus and outputs
  input wire diag_record_pkg::rec_req_t rec_req,
  input wire diag_record_pkg::rec_rsp_t rec_rsp,
  input wire logic [7:0][15:0] meas_value,
  input wire logic [7:0] chan_led
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // --------
  // Properties
  // --------
  property p_ack;
    rec_req.valid |=> rec_rsp.ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("request not answered");
  property p_short;
    rec_req.valid && rec_req.kind == acc_record_set &&
      rec_req.selector == 16'h0000 && rec_req.byte_sel > 8'h03
      |=> rec_rsp.ack && rec_rsp.err;
  endproperty
  a_short: assert property (p_short)
    else $error("short read overrun");
  property p_class;
    rec_req.valid && rec_req.kind == acc_object_index &&
      rec_req.selector == 16'h2F01 && rec_req.byte_sel == 8'h01
      |=> !rec_rsp.err && rec_rsp.data == 8'h15;
  endproperty
  a_class: assert property (p_class)
    else $error("class byte wrong");
  property p_type;
    rec_req.valid && rec_req.kind == acc_object_subindex &&
      rec_req.selector == 16'h5005 && rec_req.byte_sel == 8'h06
      |=> !rec_rsp.err && rec_rsp.data == 8'h71;
  endproperty
  a_type: assert property (p_type)
    else $error("type byte wrong");
  property p_sublow;
    rec_req.valid && rec_req.kind == acc_object_subindex &&
      rec_req.byte_sel < 8'h02 |=> rec_rsp.err;
  endproperty
  a_sublow: assert property (p_sublow)
    else $error("low subindex taken");
  property p_over;
    sample.valid && sample.chan == 3'd1 && channel_function_number[1] ==
      8'h10 && $signed(sample.code) > 18'sd19266
      |=> meas_value[1] == 16'h7FFF && chan_led[1];
  endproperty
  a_over: assert property (p_over)
    else $error("overflow missed");
  property p_under;
    sample.valid && sample.chan == 3'd3 && channel_function_number[3] ==
      8'h20 && $signed(sample.code) < -18'sd3277
      |=> meas_value[3] == 16'h8000 && chan_led[3];
  endproperty
  a_under: assert property (p_under)
    else $error("underflow missed");
  property p_off;
    sample.valid && channel_function_number[sample.chan] == 8'hFF &&
      $stable(channel_function_number) |=> $stable(meas_value);
  endproperty
  a_off: assert property (p_off)
    else $error("idle channel measured");
  c_over: cover property (sample.valid && $signed(sample.code) > 18'sd19266);
  c_err: cover property (rec_rsp.ack && rec_rsp.err);
  c_led: cover property (chan_led != 8'h00);
endmodule
bind analog_input_diag_record diag_record_props diag_record_props_inst (
  .core_clk(core_clk), .rstn(rstn),
  .channel_function_number(channel_function_number), .sample(sample),
  .aux_supply_ok(aux_supply_ok), .internal_comm_err(internal_comm_err),
  .rec_req(rec_req), .rec_rsp(rec_rsp), .meas_value(meas_value),
  .chan_led(chan_led));

// ===== test/record_host.sv
// Purpose: Host side of the record bus, issuing single byte reads.
// Assumes: The device answers one cycle after taking a request.
// Notes: Released selector and byte fields show inverted values so stale data is not reused.
`timescale 1ns/100ps
module record_host
  import diag_record_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Request to the device
  output diag_record_pkg::rec_req_t rec_req
);
  initial rec_req = '0;
  task automatic rd(input access_kind_t k, input logic [15:0] s,
                    input logic [7:0] b);
    @(posedge core_clk);
    rec_req <= '{1'b1, k, s, b};
    @(posedge core_clk);
    rec_req <= '{1'b0, k, ~s, ~b};
  endtask
endmodule

// ===== test/tb_analog_input_diag_record.sv
// Purpose: Self-checking bench for the diagnostic record block.
// Assumes: 40 MHz core_clk; reset held for 20 cycles.
// Notes: Stamp low bytes depend on run timing, so only known values are read.
`timescale 1ns/100ps
module tb_analog_input_diag_record;
  import diag_record_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0][7:0] fn = {8{8'h10}};
  sample_t sample = '0;
  logic aux_ok = 1'b1;
  logic comm_err = 1'b0;
  rec_req_t rec_req;
  rec_rsp_t rec_rsp;
  logic [7:0][15:0] meas_value;
  logic [7:0] chan_led;
  logic [8:0] q[$];
  int miscompares = 0;
  int checks_done = 0;
  always #12.5 core_clk = ~core_clk;
  analog_input_diag_record analog_input_diag_record_inst (
    .core_clk(core_clk), .rstn(rstn), .channel_function_number(fn),
    .sample(sample), .aux_supply_ok(aux_ok), .internal_comm_err(comm_err),
    .rec_req(rec_req), .rec_rsp(rec_rsp), .meas_value(meas_value),
    .chan_led(chan_led));
  record_host record_host_inst (.core_clk(core_clk), .rec_req(rec_req));
  // --------
  // Tasks
  // --------
  task automatic cmp(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic rd(input access_kind_t k, input logic [15:0] s,
                    input logic [7:0] b, input logic [8:0] e);
    q.push_back(e);
    record_host_inst.rd(k, s, b);
  endtask
  task automatic rs(input logic [7:0] b, input logic [8:0] e);
    rd(acc_record_set, 16'h0001, b, e);
  endtask
  task automatic smp(input logic [2:0] c, input logic [17:0] v);
    @(posedge core_clk);
    sample <= '{1'b1, c, v};
    @(posedge core_clk);
    sample.valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Answers are paired with notes in request order.
  always @(posedge core_clk) begin
    if (rec_rsp.ack === 1'b1) begin
      if (q.size() == 0)
        cmp("spare answer", 16'h0, 16'h1);
      else
        cmp("rec_rsp", {7'h0, q.pop_front()},
            {7'h0, rec_rsp.err, rec_rsp.data});
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    int c;
    void'($urandom(32'h46d5a72c));
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
    rs(8'h00, 9'h000);
    rs(8'h01, 9'h015);
    rd(acc_object_index, 16'h2F01, 8'h01, 9'h015);
    rd(acc_object_index, 16'h2F01, 8'h02, 9'h000);
    rd(acc_object_index, 16'h2F01, 8'h03, 9'h000);
    rd(acc_object_subindex, 16'h5005, 8'h06, 9'h071);
    rd(acc_object_subindex, 16'h5005, 8'h07, 9'h008);
    rs(8'h06, 9'h008);
    rs(8'h13, 9'h000);
    rd(acc_record_set, 16'h0000, 8'h03, 9'h000);
    rd(acc_record_set, 16'h0000, 8'h04, 9'h100);
    rd(acc_record_set, 16'h0002, 8'h00, 9'h100);
    rd(acc_object_index, 16'h2F00, 8'h01, 9'h015);
    rd(acc_object_index, 16'h2F00, 8'h04, 9'h100);
    rd(acc_object_subindex, 16'h5005, 8'h01, 9'h100);
    rd(acc_object_subindex, 16'h5005, 8'h16, 9'h100);
    $display("record access test done");
    for (int i = 0; i < 6; i++) begin
      c = (i == 5) ? 16384 : $urandom_range(19266, 0);
      smp(3'd4, 18'(c));
      cmp("meas_value[4]", 16'((c * 27648) >>> 14), meas_value[4]);
    end
    smp(3'd1, 18'sd20000);
    cmp("meas_value[1]", 16'h7FFF, meas_value[1]);
    cmp("chan_led", 16'h0002, {8'h0, chan_led});
    rs(8'h07, 9'h002);
    rs(8'h09, 9'h080);
    rs(8'h00, 9'h00C);
    fn[3] <= 8'h20;
    smp(3'd3, -18'sd4000);
    cmp("meas_value[3]", 16'h8000, meas_value[3]);
    rd(acc_object_subindex, 16'h5005, 8'h0D, 9'h040);
    smp(3'd3, 18'sd8192);
    cmp("meas_value[3]", 16'h2000, meas_value[3]);
    smp(3'd1, 18'sd100);
    rs(8'h07, 9'h000);
    $display("scaling test done");
    fn[5] <= 8'h33;
    fn[4] <= 8'hFF;
    smp(3'd4, 18'sd30000);
    cmp("meas_value[4]", 16'h0000, meas_value[4]);
    cmp("chan_led", 16'h0020, {8'h0, chan_led});
    rs(8'h0D, 9'h001);
    rs(8'h0C, 9'h000);
    rs(8'h00, 9'h088);
    fn[5] <= 8'h10;
    fn[4] <= 8'h10;
    comm_err <= 1'b1;
    aux_ok <= 1'b0;
    repeat (5) @(posedge core_clk);
    rs(8'h03, 9'h010);
    rs(8'h00, 9'h017);
    comm_err <= 1'b0;
    aux_ok <= 1'b1;
    repeat (5) @(posedge core_clk);
    rs(8'h00, 9'h000);
    $display("status test done");
    repeat (2) @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    rs(8'h00, 9'h000);
    rs(8'h10, 9'h000);
    $display("reset test done");
    repeat (4) @(posedge core_clk);
    cmp("pending answers", 16'h0, 16'(q.size()));
    report_and_stop;
  end
endmodule
